/* File: hw/msm_pkg.sv */
// constants and types for the modem spi master
package msm_pkg;

  // ---------------------------------------------------------------
  // clock and bit rate
  // ---------------------------------------------------------------
  localparam int CORE_CLK_HZ = 250_000_000;
  localparam int SCK_MAX_HZ  = 8_000_000;
  // least half period of the serial clock, rounded up
  localparam int HALF_MIN_INT =
    (CORE_CLK_HZ + 2 * SCK_MAX_HZ - 1) / (2 * SCK_MAX_HZ);
  localparam logic [7:0] HALF_MIN_CYC = 8'(HALF_MIN_INT);

  // ---------------------------------------------------------------
  // shifter geometry and reset values
  // ---------------------------------------------------------------
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [7:0] BYTE_RST      = 8'h00;
  localparam logic [3:0] BITCNT_RST    = 4'h0;

  // ---------------------------------------------------------------
  // shared port e pins, bit 0 is port e bit 2
  // ---------------------------------------------------------------
  localparam int PIN_MISO = 0;
  localparam int PIN_MOSI = 1;
  localparam int PIN_SCK  = 2;
  localparam int PIN_SS   = 3;

  typedef struct packed {
    logic ss_n;  // port e bit 5, modem chip enable
    logic sck;   // port e bit 4, serial_clock_pin
    logic mosi;  // port e bit 3
    logic miso;  // port e bit 2
  } msm_pe_t;

  // direction while the controller owns the pins
  localparam msm_pe_t PE_OE_SPI = '{ss_n: 1'b1, sck: 1'b1,
                                    mosi: 1'b1, miso: 1'b0};

  // ---------------------------------------------------------------
  // shifter states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_LEAD  = 3'b001,
    ST_HIGH  = 3'b010,
    ST_LOW   = 3'b011,
    ST_GAP   = 3'b100,
    ST_TRAIL = 3'b101
  } msm_state_t;

endpackage : msm_pkg

/* File: hw/msm_top.sv */
// modem spi master: buffered transmit, buffered receive, pin mux
// What this block does
// - Master only, always generates serial clock
// - Programmable rate, never above 8 MHz
// - Clock idles low, sample first edge, MSB first
// - Written byte buffered, loaded at transfer start
// - Received byte copied into separate receive buffer
// - Clock and MOSI driven out, MISO shifted in
// - Slave select output drives modem chip enable
// - Enabled controller sets direction of its pins
// - Port E bits 2-5 fall back to GPIO
module msm_top (
  input  wire logic           core_clk,   // 250 MHz core clock
  input  wire logic           arst_n,     // async reset, active low
  input  wire logic           enable,     // controller owns the pins
  input  wire logic [7:0]     rate_div,   // half period minus one, in core cycles
  input  wire logic [7:0]     tx_data,    // byte to send
  input  wire logic           tx_last,    // byte ends the transaction
  input  wire logic           tx_valid,   // write strobe
  output logic                tx_ready,   // transmit buffer empty
  output logic [7:0]          rx_data,    // last received byte
  output logic                rx_valid,   // receive buffer full
  input  wire logic           rx_read,    // receive buffer taken
  output logic                rx_overrun, // byte lost, sticky
  output logic                busy,       // transaction in progress
  input  wire msm_pkg::msm_pe_t gpio_out, // gpio data for the pins
  input  wire msm_pkg::msm_pe_t gpio_dir, // gpio direction, 1 = out
  output msm_pkg::msm_pe_t    gpio_in,    // synced pin levels
  input  wire msm_pkg::msm_pe_t pin_in,   // pin levels
  output msm_pkg::msm_pe_t    pin_out,    // pin drive values
  output msm_pkg::msm_pe_t    pin_oe      // pin enables, 1 = drive
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  msm_pkg::msm_state_t state_reg;
  msm_pkg::msm_pe_t    pin_meta_reg;
  msm_pkg::msm_pe_t    pin_sync_reg;
  logic [7:0]          tx_buf_reg;
  logic                tx_buf_last_reg;
  logic                tx_full_reg;
  logic [7:0]          shift_reg;
  logic                byte_last_reg;
  logic [3:0]          bit_cnt_reg;
  logic [7:0]          cnt_reg;
  logic                sck_reg;
  logic                mosi_reg;
  logic                ss_n_reg;
  logic [7:0]          rx_data_reg;
  logic                rx_valid_reg;
  logic                rx_ovr_reg;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire logic [7:0] half_cyc;
  wire logic       tick;
  wire logic       in_idle;
  wire logic       load_idle;
  wire logic       load_gap;
  wire logic       last_bit;
  wire logic       byte_done;
  wire logic       load_next;
  wire logic       rise;
  wire logic       tx_write;
  wire msm_pkg::msm_pe_t spi_out;

  // clamp rate to the modem ceiling
  assign half_cyc  = (rate_div < msm_pkg::HALF_MIN_CYC) ?
                     msm_pkg::HALF_MIN_CYC : rate_div;
  assign tick      = (cnt_reg == 8'h00);
  assign in_idle   = (state_reg == msm_pkg::ST_IDLE);
  assign load_idle = in_idle && tx_full_reg;
  assign load_gap  = (state_reg == msm_pkg::ST_GAP) && tx_full_reg;
  assign last_bit  = (bit_cnt_reg == msm_pkg::BITS_PER_BYTE);
  assign byte_done = (state_reg == msm_pkg::ST_HIGH) && tick && last_bit;
  assign load_next = byte_done && !byte_last_reg && tx_full_reg;
  assign rise      = tick && ((state_reg == msm_pkg::ST_LEAD) ||
                              (state_reg == msm_pkg::ST_LOW));
  assign tx_write  = tx_valid && tx_ready;
  assign tx_ready  = !tx_full_reg;
  assign rx_data   = rx_data_reg;
  assign rx_valid  = rx_valid_reg;
  assign rx_overrun = rx_ovr_reg;
  assign busy      = !in_idle;
  assign gpio_in   = pin_sync_reg;

  assign spi_out = '{ss_n: ss_n_reg, sck: sck_reg,
                     mosi: mosi_reg, miso: 1'b0};
  // module direction overrides gpio while enabled
  assign pin_out = enable ? spi_out : gpio_out;
  assign pin_oe  = enable ? msm_pkg::PE_OE_SPI : gpio_dir;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end else begin
      pin_meta_reg <= pin_in;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // ---------------------------------------------------------------
  // transmit buffer
  // ---------------------------------------------------------------
  // hold byte until the shifter takes it
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_full_reg     <= 1'b0;
      tx_buf_reg      <= msm_pkg::BYTE_RST;
      tx_buf_last_reg <= 1'b0;
    end else if (tx_write) begin
      tx_full_reg     <= 1'b1;
      tx_buf_reg      <= tx_data;
      tx_buf_last_reg <= tx_last;
    end else if (enable && (load_idle || load_gap || load_next)) begin
      tx_full_reg     <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // half period timer
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= 8'h00;
    end else if (!enable || in_idle || load_gap || tick) begin
      cnt_reg <= half_cyc;
    end else if (state_reg != msm_pkg::ST_GAP) begin
      cnt_reg <= cnt_reg - 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // shifter sequence
  // ---------------------------------------------------------------
  // serial clock always made here
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg     <= msm_pkg::ST_IDLE;
      sck_reg       <= 1'b0;
      mosi_reg      <= 1'b0;
      ss_n_reg      <= 1'b1;
      shift_reg     <= msm_pkg::BYTE_RST;
      byte_last_reg <= 1'b0;
      bit_cnt_reg   <= msm_pkg::BITCNT_RST;
    end else if (!enable) begin
      state_reg <= msm_pkg::ST_IDLE;
      sck_reg   <= 1'b0;
      ss_n_reg  <= 1'b1;
    end else begin
      unique case (state_reg)
        msm_pkg::ST_IDLE, msm_pkg::ST_GAP: begin
          // chip enable asserted at transaction start
          if (tx_full_reg) begin
            state_reg     <= msm_pkg::ST_LEAD;
            ss_n_reg      <= 1'b0;
            shift_reg     <= tx_buf_reg;
            mosi_reg      <= tx_buf_reg[7];
            byte_last_reg <= tx_buf_last_reg;
            bit_cnt_reg   <= msm_pkg::BITCNT_RST;
          end
        end
        msm_pkg::ST_LEAD, msm_pkg::ST_LOW: begin
          // sample on rising edge, msb first
          if (tick) begin
            state_reg   <= msm_pkg::ST_HIGH;
            sck_reg     <= 1'b1;
            shift_reg   <= {shift_reg[6:0], pin_sync_reg.miso};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
        end
        msm_pkg::ST_HIGH: begin
          if (tick) begin
            sck_reg <= 1'b0;
            if (!last_bit) begin
              state_reg <= msm_pkg::ST_LOW;
              mosi_reg  <= shift_reg[7];
            end else if (byte_last_reg) begin
              state_reg <= msm_pkg::ST_TRAIL;
            end else if (tx_full_reg) begin
              // next byte follows with chip enable held
              state_reg     <= msm_pkg::ST_LEAD;
              shift_reg     <= tx_buf_reg;
              mosi_reg      <= tx_buf_reg[7];
              byte_last_reg <= tx_buf_last_reg;
              bit_cnt_reg   <= msm_pkg::BITCNT_RST;
            end else begin
              state_reg <= msm_pkg::ST_GAP;
            end
          end
        end
        msm_pkg::ST_TRAIL: begin
          // release only after the final byte
          if (tick) begin
            state_reg <= msm_pkg::ST_IDLE;
            ss_n_reg  <= 1'b1;
          end
        end
        default: begin
          state_reg <= msm_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // receive buffer
  // ---------------------------------------------------------------
  // copy completed byte, new byte wins over read
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_data_reg  <= msm_pkg::BYTE_RST;
      rx_valid_reg <= 1'b0;
      rx_ovr_reg   <= 1'b0;
    end else if (byte_done && enable) begin
      rx_data_reg  <= shift_reg;
      rx_valid_reg <= 1'b1;
      if (rx_valid_reg && !rx_read) begin
        rx_ovr_reg <= 1'b1;
      end
    end else if (rx_read) begin
      rx_valid_reg <= 1'b0;
      rx_ovr_reg   <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [8:0] hi_len_reg;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      hi_len_reg <= 9'h000;
    end else begin
      hi_len_reg <= sck_reg ? hi_len_reg + 9'h001 : 9'h000;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  idle_clock_low_a: assert property (
    in_idle |-> !sck_reg && ss_n_reg)
    else $error("serial clock or select active while idle");
  high_phase_len_a: assert property (
    $fell(sck_reg) |-> hi_len_reg >= 9'(msm_pkg::HALF_MIN_CYC))
    else $error("serial clock high phase too short");
  mosi_stable_a: assert property (
    sck_reg |-> $stable(mosi_reg))
    else $error("mosi changed while serial clock high");
  tx_load_a: assert property (
    enable && load_idle |=> state_reg == msm_pkg::ST_LEAD &&
                            !tx_full_reg && !ss_n_reg)
    else $error("transmit buffer not moved into shifter");
  rx_copy_a: assert property (
    enable && byte_done |=>
      rx_valid_reg && rx_data_reg == $past(shift_reg))
    else $error("received byte not copied to buffer");
  pin_route_a: assert property (
    enable |-> pin_out.sck == sck_reg && pin_out.mosi == mosi_reg)
    else $error("shifter not routed to pins");
  pin_dir_a: assert property (
    enable |-> pin_oe == msm_pkg::PE_OE_SPI)
    else $error("pin direction wrong while enabled");
  gpio_back_a: assert property (
    !enable |-> pin_out == gpio_out && pin_oe == gpio_dir)
    else $error("pins not returned to gpio");
  ce_hold_a: assert property (
    enable && byte_done && !byte_last_reg |=> !ss_n_reg)
    else $error("chip enable released mid transaction");
  ce_release_a: assert property (
    enable && byte_done && byte_last_reg |=> !ss_n_reg ##[1:300] ss_n_reg)
    else $error("chip enable not released after last byte");

  byte_seen_c: cover property (enable && byte_done);
  gap_seen_c: cover property (state_reg == msm_pkg::ST_GAP ##1
                              state_reg == msm_pkg::ST_LEAD);
  back2back_c: cover property (enable && load_next);
  overrun_c: cover property ($rose(rx_ovr_reg));

endmodule : msm_top

/* File: tb/msm_modem_model.sv */
// behavioural modem spi slave port
module msm_modem_model (
  input  wire logic       ss_n,     // chip enable, low active
  input  wire logic       sck,      // serial clock
  input  wire logic       mosi,     // master out
  input  wire logic [7:0] reply,    // byte to return
  output logic            miso,     // slave out
  output logic [7:0]      got_byte, // last byte taken
  output int              got_cnt   // bytes taken
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh_out = 8'h00;
  logic [7:0] sh_in  = 8'h00;
  logic       out_q  = 1'b0;
  logic [7:0] byte_q = 8'h00;
  int         cnt_q  = 0;
  int         n_bit  = 0;
  logic       sck_q  = 1'b0;
  logic       ss_n_q = 1'b1;
  assign miso     = out_q;
  assign got_byte = byte_q;
  assign got_cnt  = cnt_q;
  // one process for both pins: a release that meets a clock fall
  // is taken as a release
  always @(ss_n or sck) begin
    if (ss_n && !ss_n_q) begin
      // released line shows the inverse
      n_bit = 0;
      out_q = ~out_q;
    end else if (!ss_n && (ss_n_q || (sck_q && !sck))) begin
      sh_out = (n_bit == 0) ? reply : {sh_out[6:0], 1'b0};
      out_q  = sh_out[7];
    end else if (!ss_n && sck && !sck_q) begin
      sh_in = {sh_in[6:0], mosi};
      n_bit = (n_bit == 7) ? 0 : n_bit + 1;
      if (n_bit == 0) begin
        byte_q = sh_in;
        cnt_q  = cnt_q + 1;
      end
    end
    sck_q  = sck;
    ss_n_q = ss_n;
  end
endmodule : msm_modem_model

/* File: tb/tb_top.sv */
// self-checking bench for the modem spi master
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] tx;
    logic       last;
    logic [7:0] rx;
  } msm_row_t;
  localparam msm_row_t ROWS [4] = '{'{8'ha5, 1'b0, 8'h3c},
    '{8'h01, 1'b0, 8'hff}, '{8'h80, 1'b1, 8'h00}, '{8'h7e, 1'b1, 8'hc3}};
  logic             core_clk = 1'b0;
  logic             arst_n   = 1'b0;
  logic             enable   = 1'b1;
  logic [7:0]       rate_div = 8'h00;
  logic [7:0]       tx_data  = 8'h00;
  logic             tx_last  = 1'b0;
  logic             tx_valid = 1'b0;
  logic             rx_read  = 1'b0;
  logic             tx_ready, rx_valid, rx_overrun, busy, miso;
  logic [7:0]       rx_data, got_byte;
  msm_pkg::msm_pe_t gpio_out = 4'ha;
  msm_pkg::msm_pe_t gpio_dir = 4'h5;
  msm_pkg::msm_pe_t gpio_in, pin_in, pin_out, pin_oe;
  int               got_cnt, base, c0;
  int               error_cnt = 0;
  int               comparisons = 0;
  int               hi_run = 0;
  int               last_hi = 0;
  int               ss_rise = 0;
  // wire level from all drivers
  assign pin_in = {pin_oe.ss_n ? pin_out.ss_n : 1'b1,
                   pin_oe.sck ? pin_out.sck : 1'b0,
                   pin_oe.mosi ? pin_out.mosi : 1'b0,
                   pin_oe.miso ? pin_out.miso : miso};
  msm_top msm_top_inst (.core_clk, .arst_n, .enable, .rate_div, .tx_data,
    .tx_last, .tx_valid, .tx_ready, .rx_data, .rx_valid, .rx_read,
    .rx_overrun, .busy, .gpio_out, .gpio_dir, .gpio_in, .pin_in, .pin_out,
    .pin_oe);
  msm_modem_model msm_modem_model_inst (.ss_n(pin_in.ss_n),
    .sck(pin_in.sck), .mosi(pin_in.mosi), .reply(ROWS[got_cnt % 4].rx),
    .miso, .got_byte, .got_cnt);
  initial forever #2 core_clk = ~core_clk;
  // high phase length of the serial clock
  always @(posedge core_clk) begin
    if (pin_out.sck) begin
      hi_run <= hi_run + 1;
    end else if (hi_run != 0) begin
      last_hi <= hi_run;
      hi_run <= 0;
    end
  end
  always @(posedge pin_out.ss_n) ss_rise <= ss_rise + 1;
  task automatic end_sim;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_byte
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_byte({7'h00, got}, {7'h00, exp});
  endtask : cmp_bit
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  function automatic logic pick(input int k);
    return (k == 0) ? tx_ready : (k == 1) ? rx_valid : ~busy;
  endfunction : pick
  task automatic wait_hi(input int k);
    int n;
    n = 0;
    while (pick(k) !== 1'b1) begin
      tick(1);
      n++;
      if (n > 3000) begin
        error_cnt++;
        end_sim();
      end
    end
  endtask : wait_hi
  task automatic put(input logic [7:0] d, input logic l);
    wait_hi(0);
    tx_data = d;
    tx_last = l;
    tx_valid = 1'b1;
    tick(1);
    tx_valid = 1'b0;
  endtask : put
  task automatic take;
    rx_read = 1'b1;
    tick(1);
    rx_read = 1'b0;
  endtask : take
  initial begin
    tick(8);
    arst_n = 1'b1;
    cmp_byte({4'h0, pin_oe}, {4'h0, msm_pkg::PE_OE_SPI});
    base = ss_rise;
    put(ROWS[0].tx, ROWS[0].last);
    put(ROWS[1].tx, ROWS[1].last);
    for (int i = 0; i < 4; i++) begin
      wait_hi(1);
      cmp_byte(rx_data, ROWS[i].rx);
      cmp_byte(got_byte, ROWS[i].tx);
      cmp_byte(8'(ss_rise - base), 8'(i / 3));
      cmp_byte(8'(last_hi), 8'h11);
      take();
      if (i < 2) put(ROWS[i + 2].tx, ROWS[i + 2].last);
      $display("test row %0d done", i);
    end
    wait_hi(2);
    cmp_bit(pin_out.sck, 1'b0);
    cmp_bit(pin_out.ss_n, 1'b1);
    cmp_byte(8'(ss_rise - base), 8'h02);
    for (int r = 0; r < 2; r++) begin
      rate_div = r ? 8'h14 : 8'h05;
      put(8'hc3, 1'b1);
      wait_hi(1);
      cmp_byte(8'(last_hi), r ? 8'h15 : 8'h11);
      take();
      wait_hi(2);
      $display("test rate %0d done", r);
    end
    c0 = got_cnt;
    put(8'h5a, 1'b0);
    put(8'h66, 1'b1);
    tick(1);
    tx_data = 8'h99;
    tx_valid = 1'b1;
    tick(1);
    tx_valid = 1'b0;
    wait_hi(2);
    cmp_byte(8'(got_cnt - c0), 8'h02);
    cmp_byte(got_byte, 8'h66);
    cmp_bit(rx_overrun, 1'b1);
    cmp_byte(rx_data, ROWS[(c0 + 1) % 4].rx);
    take();
    cmp_bit(rx_valid, 1'b0);
    cmp_bit(rx_overrun, 1'b0);
    $display("test overrun done");
    base = ss_rise;
    put(8'h3c, 1'b0);
    wait_hi(1);
    tick(40);
    cmp_bit(pin_out.ss_n, 1'b0);
    cmp_bit(pin_out.sck, 1'b0);
    cmp_bit(busy, 1'b1);
    cmp_byte(got_byte, 8'h3c);
    cmp_byte(rx_data, ROWS[(c0 + 2) % 4].rx);
    take();
    put(8'hc5, 1'b1);
    wait_hi(2);
    cmp_byte(got_byte, 8'hc5);
    cmp_byte(8'(ss_rise - base), 8'h01);
    take();
    $display("test gap done");
    put(8'hff, 1'b0);
    tick(40);
    arst_n = 1'b0;
    tick(2);
    cmp_bit(tx_ready, 1'b1);
    cmp_bit(rx_valid, 1'b0);
    cmp_bit(busy, 1'b0);
    cmp_byte(rx_data, 8'h00);
    cmp_bit(pin_out.ss_n, 1'b1);
    cmp_bit(pin_out.sck, 1'b0);
    arst_n = 1'b1;
    $display("test reset done");
    enable = 1'b0;
    tick(3);
    cmp_byte({4'h0, pin_out}, {4'h0, gpio_out});
    cmp_byte({4'h0, pin_oe}, {4'h0, gpio_dir});
    cmp_byte({4'h0, gpio_in}, {4'h0, pin_in});
    enable = 1'b1;
    $display("test pin mux done");
    end_sim();
  end
endmodule : tb_top
